/* File: opmode_pkg.sv */
package opmode_pkg;

  // Operating modes, ranked by decreasing power
  typedef enum logic [2:0] {
    MODE_RUN      = 3'h0,
    MODE_SLEEP    = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_STANDBY  = 3'h3,
    MODE_SHUTDOWN = 3'h4
  } op_mode_t;

  // Sequencer states, Gray codes along the sleep/wake path through ST_LOW; ST_WAIT_HLT to ST_OFF changes three bits
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_WAIT_HLT = 3'h1,
    ST_LOW      = 3'h3,
    ST_PWR_UP   = 3'h2,
    ST_OFF      = 3'h6
  } seq_state_t;

  // Policy sub-level width and the largest legal sub-level per mode
  localparam int SUB_W = 2;
  localparam logic [1:0] SUB_MAX_RUN = 2'h2;
  localparam logic [1:0] SUB_MAX_SLEEP = 2'h2;
  localparam logic [1:0] SUB_MAX_STOP = 2'h2;
  localparam logic [1:0] SUB_MAX_STANDBY = 2'h1;

  // Functions under control
  localparam int NFUNC = 8;

  // High-performance domain settle time
  localparam int CLK_HZ = 20_000_000;
  localparam int HP_SETTLE_NS = 1000;
  localparam int HP_SETTLE_CYC_I = (HP_SETTLE_NS * (CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [7:0] HP_SETTLE_CYC = 8'(HP_SETTLE_CYC_I);

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] SUB_RST = 2'h0;

endpackage

/* File: opmode_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - Five modes RUN SLEEP STOP STANDBY SHUTDOWN
// - Core executes only in RUN
// - Peripheral interrupt wakes SLEEP/STOP/STANDBY to RUN
// - SHUTDOWN: regulator off; pin/debug/IO wake only
// - Sub-levels for four modes, none SHUTDOWN
// - Core in high-perf domain, slow peripherals low-power
// - High-perf domain on only RUN and SLEEP; code also powers it in PWR_UP while leaving STOP/STANDBY/SHUTDOWN
// - Low-power domain on except SHUTDOWN; code also powers it in PWR_UP while leaving SHUTDOWN
// - SHUTDOWN removes power from both domains
// - Disabled function gated, configuration retained
// - Optional function stays active when enabled
// - Unsupported function not gated automatically
// - Powered-off function loses configuration, resets
module opmode_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core side
  input wire logic [2:0] mode_req,
  input wire logic [1:0] sub_req,
  input wire logic sleep_req,
  input wire logic core_halted,
  output logic core_run_en,
  // Wake sources
  input wire logic periph_irq,
  input wire logic external_reset_pin_n,
  input wire logic swd_wake,
  input wire logic io_match,
  // Per-function policy, one bit per function
  input wire logic [7:0] func_sw_en,
  input wire logic [7:0] func_in_hp,
  input wire logic [7:0] func_opt_mask,
  input wire logic [7:0] func_ns_mask,
  // Power, gating and mode/sub-level status outputs
  output logic high_perf_power_domain,
  output logic low_power_domain,
  output logic core_regulator_en,
  output logic [7:0] func_clk_en,
  output logic [7:0] func_cfg_rst,
  output logic [2:0] cur_mode,
  output logic [1:0] cur_sub
);

  // Pin-side inputs pass two flops before use
  logic [3:0] sync1_r, sync2_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r <= 4'h1;
      sync2_r <= 4'h1;
    end else begin
      sync1_r <= {io_match, swd_wake, periph_irq, external_reset_pin_n};
      sync2_r <= sync1_r;
    end
  end
  logic rstpin_n_s, irq_s, swd_s, io_s;
  assign {io_s, swd_s, irq_s, rstpin_n_s} = sync2_r;
  logic shut_wake;
  assign shut_wake = !rstpin_n_s || swd_s || io_s;

  // Clamp sub-level to what each mode offers
  function automatic logic [1:0] clamp_sub(input logic [2:0] m,
                                          input logic [1:0] s);
    logic [1:0] mx;
    mx = 2'h0;
    case (m)
      opmode_pkg::MODE_RUN:     mx = opmode_pkg::SUB_MAX_RUN;
      opmode_pkg::MODE_SLEEP:   mx = opmode_pkg::SUB_MAX_SLEEP;
      opmode_pkg::MODE_STOP:    mx = opmode_pkg::SUB_MAX_STOP;
      opmode_pkg::MODE_STANDBY: mx = opmode_pkg::SUB_MAX_STANDBY;
      default:                  mx = 2'h0;
    endcase
    clamp_sub = (s > mx) ? mx : s;
  endfunction

  opmode_pkg::seq_state_t st_r, st_nxt;
  logic [2:0] mode_r, mode_nxt, tgt_r, tgt_nxt;
  logic [1:0] sub_r, sub_nxt, tsub_r, tsub_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] lost_r, lost_nxt;

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    sub_nxt = sub_r;
    tgt_nxt = tgt_r;
    tsub_nxt = tsub_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      opmode_pkg::ST_RUN: begin
        sub_nxt = clamp_sub(opmode_pkg::MODE_RUN, sub_req);
        if (sleep_req && mode_req != opmode_pkg::MODE_RUN &&
            mode_req <= opmode_pkg::MODE_SHUTDOWN) begin
          tgt_nxt = mode_req;
          tsub_nxt = clamp_sub(mode_req, sub_req);
          st_nxt = opmode_pkg::ST_WAIT_HLT;
        end
      end
      opmode_pkg::ST_WAIT_HLT: begin
        if (core_halted) begin
          mode_nxt = tgt_r;
          sub_nxt = tsub_r;
          st_nxt = (tgt_r == opmode_pkg::MODE_SHUTDOWN) ?
                   opmode_pkg::ST_OFF : opmode_pkg::ST_LOW;
        end
      end
      opmode_pkg::ST_LOW: begin
        if (irq_s) begin
          cnt_nxt = (mode_r == opmode_pkg::MODE_SLEEP) ? 8'h01 :
                    opmode_pkg::HP_SETTLE_CYC;
          st_nxt = opmode_pkg::ST_PWR_UP;
        end
      end
      opmode_pkg::ST_PWR_UP: begin
        // Core held until high-perf domain has settled
        if (cnt_r <= 8'h01) begin
          mode_nxt = opmode_pkg::MODE_RUN;
          sub_nxt = opmode_pkg::SUB_RST;
          cnt_nxt = 8'h00;
          st_nxt = opmode_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      opmode_pkg::ST_OFF: begin
        // Only pin, debug or IO match leave shutdown
        if (shut_wake) begin
          cnt_nxt = opmode_pkg::HP_SETTLE_CYC;
          sub_nxt = 2'h0;
          st_nxt = opmode_pkg::ST_PWR_UP;
        end
      end
      default: st_nxt = opmode_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= opmode_pkg::ST_RUN;
      mode_r <= opmode_pkg::MODE_RST;
      sub_r <= opmode_pkg::SUB_RST;
      tgt_r <= opmode_pkg::MODE_RST;
      tsub_r <= opmode_pkg::SUB_RST;
      cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      sub_r <= sub_nxt;
      tgt_r <= tgt_nxt;
      tsub_r <= tsub_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Domain power follows the registered mode; PWR_UP powers high-perf
  logic hp_on, lp_on;
  assign hp_on = (mode_r == opmode_pkg::MODE_RUN ||
                  mode_r == opmode_pkg::MODE_SLEEP ||
                  st_r == opmode_pkg::ST_PWR_UP);
  assign lp_on = (mode_r != opmode_pkg::MODE_SHUTDOWN ||
                  st_r == opmode_pkg::ST_PWR_UP);

  // Per-function gating; an unpowered function's config is lost
  logic [7:0] clk_nxt;
  always_comb begin
    clk_nxt = 8'h00;
    lost_nxt = 8'h00;
    for (int i = 0; i < opmode_pkg::NFUNC; i++) begin
      if (func_in_hp[i] ? !hp_on : !lp_on) begin
        lost_nxt[i] = 1'b1;
      end else if (mode_r == opmode_pkg::MODE_RUN) begin
        clk_nxt[i] = func_sw_en[i];
      end else if (func_ns_mask[i]) begin
        clk_nxt[i] = func_sw_en[i];
      end else if (func_opt_mask[i]) begin
        clk_nxt[i] = func_sw_en[i];
      end else begin
        clk_nxt[i] = 1'b0;
      end
    end
  end

  logic [7:0] clk_r;
  logic hp_r, lp_r, run_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_r <= 8'h00;
      lost_r <= 8'hFF;
      hp_r <= 1'b1;
      lp_r <= 1'b1;
      run_r <= 1'b0;
    end else begin
      clk_r <= clk_nxt;
      lost_r <= lost_nxt;
      hp_r <= hp_on;
      lp_r <= lp_on;
      run_r <= (st_nxt == opmode_pkg::ST_RUN) ||
               (st_nxt == opmode_pkg::ST_WAIT_HLT);
    end
  end

  assign core_run_en = run_r;
  assign high_perf_power_domain = hp_r;
  assign low_power_domain = lp_r;
  assign core_regulator_en = lp_r;
  assign func_clk_en = clk_r;
  assign func_cfg_rst = lost_r;
  assign cur_mode = mode_r;
  assign cur_sub = sub_r;

  // Checks
  // Ties the core enable to the mode and domain registers, not its own state
  property p_core_only_run;
    @(posedge mclk) disable iff (rst)
      core_run_en |-> (cur_mode == opmode_pkg::MODE_RUN &&
                       high_perf_power_domain);
  endproperty
  a_core_only_run: assert property (p_core_only_run)
    else $error("core runs outside RUN");

  property p_irq_wake;
    @(posedge mclk) disable iff (rst)
      (st_r == opmode_pkg::ST_LOW && irq_s) |=> ##[0:60]
      (st_r == opmode_pkg::ST_RUN);
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("interrupt did not wake to RUN");

  property p_shut_hold;
    @(posedge mclk) disable iff (rst)
      (st_r == opmode_pkg::ST_OFF && !shut_wake) |=>
      (st_r == opmode_pkg::ST_OFF);
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("shutdown left without legal wake");

  property p_sub_range;
    @(posedge mclk) disable iff (rst)
      (cur_mode == opmode_pkg::MODE_SHUTDOWN) |-> (cur_sub == 2'h0);
  endproperty
  a_sub_range: assert property (p_sub_range)
    else $error("shutdown has a sub-level");

  property p_hp_off;
    @(posedge mclk) disable iff (rst)
      ($past(mode_r) == opmode_pkg::MODE_STOP &&
       $past(st_r) == opmode_pkg::ST_LOW) |-> !high_perf_power_domain;
  endproperty
  a_hp_off: assert property (p_hp_off)
    else $error("high-perf domain on in STOP");

  property p_shut_both_off;
    @(posedge mclk) disable iff (rst)
      ($past(st_r) == opmode_pkg::ST_OFF) |->
      (!high_perf_power_domain && !low_power_domain);
  endproperty
  a_shut_both_off: assert property (p_shut_both_off)
    else $error("domain powered in shutdown");

  property p_settle;
    @(posedge mclk) disable iff (rst)
      (st_r == opmode_pkg::ST_OFF && shut_wake) |=>
      !core_run_en [*8];
  endproperty
  a_settle: assert property (p_settle)
    else $error("core released before domain settled");

  property p_halt_first;
    @(posedge mclk) disable iff (rst)
      (st_r == opmode_pkg::ST_WAIT_HLT && !core_halted) |=>
      (mode_r == opmode_pkg::MODE_RUN);
  endproperty
  a_halt_first: assert property (p_halt_first)
    else $error("mode entered before core halted");

  // With the low-power domain off every function is unpowered and unclocked
  property p_lost;
    @(posedge mclk) disable iff (rst)
      !low_power_domain |-> (func_cfg_rst == 8'hFF &&
                             func_clk_en == 8'h00);
  endproperty
  a_lost: assert property (p_lost)
    else $error("function kept while both domains off");

  c_sleep: cover property (@(posedge mclk) disable iff (rst)
    st_r == opmode_pkg::ST_LOW ##1 st_r == opmode_pkg::ST_PWR_UP);
  c_shut: cover property (@(posedge mclk) disable iff (rst)
    st_r == opmode_pkg::ST_OFF ##1 st_r == opmode_pkg::ST_PWR_UP);
  c_wait: cover property (@(posedge mclk) disable iff (rst)
    st_r == opmode_pkg::ST_WAIT_HLT [*3]);

endmodule

/* File: core_model.sv */
`timescale 1ns/1ps
// Core stand-in: halts a few cycles after asking to sleep, resumes on enable
module core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core side
  input wire logic sleep_req,
  input wire logic core_run_en,
  input wire logic [2:0] halt_dly,
  output logic core_halted
);
  logic [3:0] cnt_r;
  logic busy_r;
  // Halt lags the request so entry before halt would be seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_halted <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (sleep_req && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= {1'b0, halt_dly};
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy_r) begin
      core_halted <= 1'b1;
      busy_r <= 1'b0;
    end else if (core_run_en) begin
      core_halted <= 1'b0;
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk, rst, sleep_req, periph_irq, pin_n, swd_wake, io_match;
  logic [2:0] mode_req, hdly, m;
  logic [1:0] sub_req, s;
  logic [7:0] sw_en, in_hp, optional_state_kept, ns, exp_v;
  logic core_halted, core_run_en, hp, lp, reg_en;
  logic [7:0] clk_en, cfg_rst;
  logic [2:0] cur_mode;
  logic [1:0] cur_sub;
  int bad_count, tests_run, seed, cyc, k;

  opmode_ctrl uut (.mclk(mclk), .rst(rst), .mode_req(mode_req),
    .sub_req(sub_req), .sleep_req(sleep_req), .core_halted(core_halted),
    .core_run_en(core_run_en), .periph_irq(periph_irq),
    .external_reset_pin_n(pin_n), .swd_wake(swd_wake), .io_match(io_match),
    .func_sw_en(sw_en), .func_in_hp(in_hp), .func_opt_mask(optional_state_kept),
    .func_ns_mask(ns), .high_perf_power_domain(hp), .low_power_domain(lp),
    .core_regulator_en(reg_en), .func_clk_en(clk_en),
    .func_cfg_rst(cfg_rst), .cur_mode(cur_mode), .cur_sub(cur_sub));
  core_model core (.mclk(mclk), .rst(rst), .sleep_req(sleep_req),
    .core_run_en(core_run_en), .halt_dly(hdly), .core_halted(core_halted));

  // 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Cuts a hang short well past the longest expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Sub-level is clamped to the mode's largest legal level
  function automatic logic [1:0] clamp(input logic [2:0] md,
                                       input logic [1:0] sb);
    logic [1:0] mx;
    case (md)
      3'h0: mx = opmode_pkg::SUB_MAX_RUN;
      3'h1: mx = opmode_pkg::SUB_MAX_SLEEP;
      3'h2: mx = opmode_pkg::SUB_MAX_STOP;
      3'h3: mx = opmode_pkg::SUB_MAX_STANDBY;
      default: mx = 2'h0;
    endcase
    return (sb > mx) ? mx : sb;
  endfunction

  task automatic wait_mode(input logic [2:0] md);
    k = 0;
    while (cur_mode !== md && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask

  initial begin
    rst = 1'b1; sleep_req = 1'b0; periph_irq = 1'b0; pin_n = 1'b1;
    swd_wake = 1'b0; io_match = 1'b0; mode_req = 3'h0; sub_req = 2'h0;
    sw_en = 8'h00; in_hp = 8'h00; optional_state_kept = 8'h00; ns = 8'h00; hdly = 3'h2;
    seed = 25;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Values held while in reset
    #1 chk(8'(core_run_en), 8'h00);
    chk(cfg_rst, 8'hFF);
    chk(8'(hp & lp & reg_en), 8'h01);
    chk(clk_en, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(8'(core_run_en), 8'h01);
    chk(cfg_rst, 8'h00);
    for (int i = 0; i < 16; i++) begin
      m = (i < 4) ? 3'(i + 1) : 3'h1 + 3'($random(seed) & 3);
      s = 2'($random(seed));
      hdly <= 3'h2 + 3'({$random(seed)} % 6);
      sw_en <= 8'($random(seed)); in_hp <= 8'($random(seed));
      optional_state_kept <= 8'($random(seed)); ns <= 8'($random(seed));
      mode_req <= m; sub_req <= s; sleep_req <= 1'b1;
      @(posedge mclk);
      sleep_req <= 1'b0;
      @(posedge mclk);
      #1 chk(8'(cur_mode), 8'h00);
      wait_mode(m);
      repeat (2) @(posedge mclk);
      #1 chk(8'(cur_mode), 8'(m));
      chk(8'(cur_sub), 8'(clamp(m, s)));
      chk(8'(core_run_en), 8'h00);
      chk(8'(hp), 8'(m == 3'h1));
      chk(8'(lp), 8'(m != 3'h4));
      chk(8'(reg_en), 8'(m != 3'h4));
      chk(cfg_rst, (m == 3'h4) ? 8'hFF : (m == 3'h1) ? 8'h00 : in_hp);
      // Lost functions are unclocked; kept ones run only if optional or NS
      exp_v = sw_en & (optional_state_kept | ns) & ((m == 3'h1) ? 8'hFF :
              (m == 3'h4) ? 8'h00 : ~in_hp);
      chk(clk_en, exp_v);
      if (m == 3'h4) begin
        periph_irq <= 1'b1;
        repeat (10) @(posedge mclk);
        #1 chk(8'(cur_mode), 8'h04);
        periph_irq <= 1'b0;
      end
      // Wake; domain must be up by the cycle the core is released
      @(posedge mclk);
      if (m != 3'h4) periph_irq <= 1'b1;
      else if (i % 3 == 0) pin_n <= 1'b0;
      else if (i % 3 == 1) swd_wake <= 1'b1;
      else io_match <= 1'b1;
      k = 0;
      while (core_run_en !== 1'b1 && k < 100) begin
        @(posedge mclk);
        #1 chk(8'(core_run_en & ~hp), 8'h00);
        k++;
      end
      periph_irq <= 1'b0; pin_n <= 1'b1; swd_wake <= 1'b0; io_match <= 1'b0;
      chk(8'(core_run_en), 8'h01);
      // Two sync flops, one decode edge, then the power-up count
      exp_v = (m == 3'h1) ? 8'h04 : 8'(3 + opmode_pkg::HP_SETTLE_CYC_I);
      chk(8'(k), exp_v);
      chk(8'(cur_mode), 8'h00);
      chk(8'(hp), 8'h01);
      repeat (4) @(posedge mclk);
      // Back in RUN every enabled function is clocked and configured
      #1 chk(clk_en, sw_en);
      chk(cfg_rst, 8'h00);
      chk(8'(cur_sub), 8'(clamp(3'h0, s)));
    end
    // A mode code past SHUTDOWN is refused and the core keeps running
    mode_req <= 3'h5; sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (10) @(posedge mclk);
    #1 chk(8'(cur_mode), 8'h00);
    chk(8'(core_run_en), 8'h01);
    // Reset in mid-run from STOP returns to RUN with both domains up
    mode_req <= 3'h2; sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    wait_mode(3'h2);
    chk(8'(cur_mode), 8'h02);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(8'(cur_mode), 8'h00);
    chk(8'(hp & lp & ~core_run_en), 8'h01);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(8'(core_run_en), 8'h01);
    chk(cfg_rst, 8'h00);
    end_of_test();
  end
endmodule
